/* File: inc/crl_pkg.sv */
// Constants and types shared by both ends of the config region write lock.
// Assumes one clock clk_sys (25 MHz) and an active-high asynchronous reset.
// ---------------------------------------------------------------------------
// Summary of operation
// - Five independent lock registers, one region each
// - Writes to a locked region are dropped
// - Own lock code locks, own unlock code unlocks
// - Locked fifth region write blocks whole space
// - That faulting write returns a bus error
// - Blocked space stays blocked until reset
// - Fifth lock code is 0x143f832c
// - Fifth unlock code is 0x6f361e05
// - Software reads fifth lock before touching region
// - Unlock, modify pad registers, then relock
// - Never write pad registers while fifth locked
// ---------------------------------------------------------------------------
package crl_pkg;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int NUM_LOCK  = 5;
   localparam int REGION_W  = 3;
   localparam int WORDS     = 1 << (ADDR_W - 2);

   // Address map (word addresses): lock registers, then five regions
   localparam logic [ADDR_W-1:0] LOCK_BASE   = 12'h000;
   localparam logic [ADDR_W-1:0] REGION_BASE = 12'h100;
   localparam int                REGION_SPAN = 128;   // words per region
   localparam int                REGION5_IDX = 4;     // fifth region index

   // Lock and unlock codes, one pair per region
   localparam logic [DATA_W-1:0] LOCK_CODE [NUM_LOCK] = '{
      32'h1a1a0001, 32'h1a1a0002, 32'h1a1a0003, 32'h1a1a0004,
      32'h143f832c};
   localparam logic [DATA_W-1:0] UNLOCK_CODE [NUM_LOCK] = '{
      32'h2b2b0001, 32'h2b2b0002, 32'h2b2b0003, 32'h2b2b0004,
      32'h6f361e05};
   localparam logic [NUM_LOCK-1:0] LOCK_RESET = 5'h1f;

   // Response codes
   typedef enum logic [1:0] {
      CRL_RESP_OKAY,
      CRL_RESP_ERR
   } crl_resp_t;

   typedef enum logic [1:0] {
      CRL_ST_IDLE,
      CRL_ST_READ_LOCK,
      CRL_ST_WRITE,
      CRL_ST_DONE
   } crl_host_st_t;
endpackage : crl_pkg

/* File: inc/crl_if.sv */
// Configuration bus between a master and the lock-protected control space.
// Assumes both ends share clk_sys and rst.
`timescale 1ns/1ps
interface crl_if;
   logic                            req;    // One-cycle request strobe
   logic                            we;     // Write when high
   logic [crl_pkg::ADDR_W-1:0]      addr;   // Word address
   logic [crl_pkg::DATA_W-1:0]      wdata;  // Write data
   logic                            ack;    // One-cycle answer strobe
   logic                            err;    // Error with ack
   logic [crl_pkg::DATA_W-1:0]      rdata;  // Read data with ack
   logic                            hung;   // Space permanently blocked

   modport dev  (input req, we, addr, wdata,
                 output ack, err, rdata, hung);
   modport host (output req, we, addr, wdata,
                 input ack, err, rdata, hung);
endinterface : crl_if

/* File: src/crl_space.sv */
// Control space with five write-lock registers guarding five regions.
// Assumes masters issue one request at a time and wait for ack.
`timescale 1ns/1ps
module crl_space (
   input  wire logic clk_sys,     // System clock
   input  wire logic rst,         // Async reset, active high
   crl_if.dev        bus,         // Configuration bus
   output logic [crl_pkg::NUM_LOCK-1:0] lock_state, // Lock state per region
   output logic                        blocked      // Space hung
);
   logic [crl_pkg::NUM_LOCK-1:0] lock, next_lock;
   logic                         hung, next_hung;
   logic                         ack, next_ack;
   logic                         err, next_err;
   logic [crl_pkg::DATA_W-1:0]   rdata, next_rdata;
   logic [crl_pkg::DATA_W-1:0]   mem [crl_pkg::WORDS];
   logic                         mem_we;
   logic                         is_lock;
   logic                         in_region;
   logic [crl_pkg::REGION_W-1:0] lidx;
   logic [crl_pkg::REGION_W-1:0] ridx;
   logic [crl_pkg::ADDR_W-1:0]   roff;
   logic [crl_pkg::ADDR_W-1:0]   waddr;

   // ------------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------------
   always_comb begin
      roff      = bus.addr - crl_pkg::REGION_BASE;
      lidx      = bus.addr[crl_pkg::REGION_W-1:0];
      ridx      = roff[crl_pkg::REGION_W+6:7];
      is_lock   = 1'b0;
      in_region = 1'b0;
      if (bus.addr < crl_pkg::LOCK_BASE + crl_pkg::ADDR_W'(crl_pkg::NUM_LOCK))
      begin
         is_lock = 1'b1;
      end else if (bus.addr >= crl_pkg::REGION_BASE &&
                   roff < crl_pkg::ADDR_W'(crl_pkg::NUM_LOCK *
                                           crl_pkg::REGION_SPAN)) begin
         in_region = 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // Next-state logic: locks, hang, response
   // ------------------------------------------------------------------------
   always_comb begin
      next_lock  = lock;
      next_hung  = hung;
      next_ack   = 1'b0;
      next_err   = 1'b0;
      next_rdata = '0;
      mem_we     = 1'b0;
      // Once hung, nothing answers again; the master stalls forever
      if (bus.req && !hung) begin
         next_ack = 1'b1;
         if (is_lock) begin
            if (bus.we) begin
               // Lock wins only on exact code; anything else is ignored
               if (bus.wdata == crl_pkg::LOCK_CODE[lidx]) begin
                  next_lock[lidx] = 1'b1;
               end else if (bus.wdata == crl_pkg::UNLOCK_CODE[lidx]) begin
                  next_lock[lidx] = 1'b0;
               end
            end else begin
               next_rdata = lock[lidx] ? crl_pkg::LOCK_CODE[lidx]
                                       : crl_pkg::UNLOCK_CODE[lidx];
            end
         end else if (bus.we) begin
            if (in_region && lock[ridx]) begin
               if (ridx == crl_pkg::REGION_W'(crl_pkg::REGION5_IDX)) begin
                  next_err  = 1'b1;
                  next_hung = 1'b1;
               end
            end else begin
               mem_we = 1'b1;
            end
         end else begin
            next_rdata = mem[bus.addr[crl_pkg::ADDR_W-1:2]];
         end
      end
   end

   // ------------------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock  <= crl_pkg::LOCK_RESET;
         hung  <= 1'b0;
         ack   <= 1'b0;
         err   <= 1'b0;
         rdata <= '0;
      end else begin
         lock  <= next_lock;
         hung  <= next_hung;
         ack   <= next_ack;
         err   <= next_err;
         rdata <= next_rdata;
      end
   end

   // Storage for region contents; no reset so it maps to RAM
   assign waddr = bus.addr;
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[waddr[crl_pkg::ADDR_W-1:2]] <= bus.wdata;
      end
   end

   assign bus.ack    = ack;
   assign bus.err    = err;
   assign bus.rdata  = rdata;
   assign bus.hung   = hung;
   assign lock_state = lock;
   assign blocked    = hung;
endmodule : crl_space

/* File: src/crl_master.sv */
// Master that updates a fifth-region register with the safe sequence.
// Assumes the control space answers each request with ack.
`timescale 1ns/1ps
module crl_master (
   input  wire logic clk_sys,   // System clock
   input  wire logic rst,       // Async reset, active high
   crl_if.host       bus,       // Configuration bus
   input  wire logic start,     // Pulse: begin update
   input  wire logic [crl_pkg::ADDR_W-1:0] pad_addr, // Target in region 5
   input  wire logic [crl_pkg::DATA_W-1:0] pad_data, // Value to write
   output logic      busy,      // Sequence running
   output logic      done       // Pulse: sequence finished
);
   localparam logic [crl_pkg::ADDR_W-1:0] LOCK5_ADDR =
      crl_pkg::LOCK_BASE + crl_pkg::ADDR_W'(crl_pkg::REGION5_IDX);
   typedef enum logic [2:0] {
      CRL_M_IDLE, CRL_M_RD, CRL_M_UNLK, CRL_M_PAD, CRL_M_LOCK
   } crl_m_st_t;

   crl_m_st_t                  st, next_st;
   logic                       req, next_req, we, next_we, wait_ack;
   logic                       next_wait;
   logic [crl_pkg::ADDR_W-1:0] addr, next_addr;
   logic [crl_pkg::DATA_W-1:0] wdata, next_wdata;
   logic                       next_done;

   // ------------------------------------------------------------------------
   // Sequencer: read lock, unlock, modify, relock
   // ------------------------------------------------------------------------
   always_comb begin
      next_st = st; next_req = 1'b0; next_we = we; next_addr = addr;
      next_wdata = wdata; next_wait = wait_ack; next_done = 1'b0;
      case (st)
         CRL_M_IDLE: begin
            if (start) begin
               next_st = CRL_M_RD; next_req = 1'b1; next_we = 1'b0;
               next_addr = LOCK5_ADDR; next_wait = 1'b1;
            end
         end
         CRL_M_RD: begin
            if (bus.ack) begin
               next_st = CRL_M_UNLK; next_req = 1'b1; next_we = 1'b1;
               next_wdata = crl_pkg::UNLOCK_CODE[crl_pkg::REGION5_IDX];
               // Unlock only if the read shows the lock code; else go straight to the pad write
               if (bus.rdata != crl_pkg::LOCK_CODE[crl_pkg::REGION5_IDX])
               begin
                  next_st = CRL_M_PAD; next_addr = pad_addr;
                  next_wdata = pad_data;
               end
            end
         end
         CRL_M_UNLK: begin
            if (bus.ack) begin
               next_st = CRL_M_PAD; next_req = 1'b1;
               next_addr = pad_addr; next_wdata = pad_data;
            end
         end
         CRL_M_PAD: begin
            if (bus.ack) begin
               next_st = CRL_M_LOCK; next_req = 1'b1; next_addr = LOCK5_ADDR;
               next_wdata = crl_pkg::LOCK_CODE[crl_pkg::REGION5_IDX];
            end
         end
         default: begin
            if (bus.ack) begin
               next_st = CRL_M_IDLE; next_wait = 1'b0; next_done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= CRL_M_IDLE; req <= 1'b0; we <= 1'b0; addr <= '0;
         wdata <= '0; wait_ack <= 1'b0; done <= 1'b0;
      end else begin
         st <= next_st; req <= next_req; we <= next_we; addr <= next_addr;
         wdata <= next_wdata; wait_ack <= next_wait; done <= next_done;
      end
   end

   assign busy      = wait_ack;
   assign bus.req   = req;
   assign bus.we    = we;
   assign bus.addr  = addr;
   assign bus.wdata = wdata;
endmodule : crl_master

/* File: sim/crl_bus_asserts.sv */
// Assertions on the bus joining the master to the control space.
// Assumes it watches the interface shared by the two design ends.
`timescale 1ns/1ps
module crl_bus_asserts (
   input logic                       clk_sys, // System clock
   input logic                       rst,     // Async reset, active high
   input logic                       req,     // Request strobe
   input logic                       we,      // Write when high
   input logic [crl_pkg::ADDR_W-1:0] addr,    // Word address
   input logic [crl_pkg::DATA_W-1:0] wdata,   // Write data
   input logic                       ack,     // Answer strobe
   input logic                       err,     // Error with ack
   input logic [crl_pkg::DATA_W-1:0] rdata,   // Read data
   input logic                       hung     // Space blocked
);
   localparam logic [31:0] LOCK5   = 32'h143f832c;
   localparam logic [31:0] UNLOCK5 = 32'h6f361e05;
   logic lk5;   // Shadow of the fifth lock as seen on the bus
   logic is_l5; // Access to the fifth lock register
   logic in_r5; // Access inside the fifth region
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------------
   // Helper: track the fifth lock from bus writes
   // ----------------------------------------------
   assign is_l5 = addr == crl_pkg::LOCK_BASE + 12'h004;
   assign in_r5 = addr >= 12'h300 && addr < 12'h380;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) lk5 <= 1'b1;
      else if (req && we && is_l5 && wdata == LOCK5) lk5 <= 1'b1;
      else if (req && we && is_l5 && wdata == UNLOCK5) lk5 <= 1'b0;
   end
   // Steps of the safe update
   sequence s_unlock; req && we && is_l5 && wdata == UNLOCK5; endsequence
   sequence s_pad;    req && we && in_r5;                     endsequence
   sequence s_relock; req && we && is_l5 && wdata == LOCK5;   endsequence
   ack_after_req_a: assert property (req && !hung |=> ack)
      else $error("request not answered next cycle");
   ack_has_cause_a: assert property (ack |-> $past(req) && !$past(hung))
      else $error("answer without a live request");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("answer longer than one cycle");
   hung_sticky_a: assert property (hung |=> hung)
      else $error("blocked space recovered");
   err_cause_a: assert property (ack |-> err == $past(req && we && in_r5 && lk5))
      else $error("error flag disagrees with lock state");
   lock5_read_a: assert property (ack && $past(req && !we && is_l5) |-> rdata == (lk5 ? LOCK5 : UNLOCK5))
      else $error("fifth lock reads wrong code");
   no_locked_pad_a: assert property (s_pad |-> !lk5)
      else $error("pad write while fifth region locked");
   safe_order_a: assert property (s_unlock |-> ##2 s_pad ##2 s_relock)
      else $error("update not followed by relock");
   check_first_a: assert property (s_unlock |-> $past(req && !we && is_l5, 2))
      else $error("unlock without reading the lock");
endmodule : crl_bus_asserts

/* File: sim/config_region_write_lock_test.sv */
// Bench: master against one space, the bench against a second space.
// Assumes the design files and the bus checker are compiled first.
`timescale 1ns/1ps
module config_region_write_lock_test;
   logic                         clk_sys, rst, start, busy, done, ok, er;
   logic                         blocked_a, blocked_b;
   logic [crl_pkg::ADDR_W-1:0]   pad_addr, a;
   logic [crl_pkg::DATA_W-1:0]   pad_data, seed, rd, d1;
   logic [crl_pkg::NUM_LOCK-1:0] lock_a, lock_b;
   int                           failures, checked, i;
   crl_if ia ();
   crl_if ib ();
   crl_space u_crl_space (.clk_sys(clk_sys), .rst(rst), .bus(ia),
      .lock_state(lock_a), .blocked(blocked_a));
   crl_master u_crl_master (.clk_sys(clk_sys), .rst(rst), .bus(ia),
      .start(start), .pad_addr(pad_addr), .pad_data(pad_data),
      .busy(busy), .done(done));
   // Second space driven by the bench so it can break the rules
   crl_space u_crl_space_fault (.clk_sys(clk_sys), .rst(rst), .bus(ib),
      .lock_state(lock_b), .blocked(blocked_b));
   crl_bus_asserts u_crl_bus_asserts (.clk_sys(clk_sys), .rst(rst),
      .req(ia.req), .we(ia.we), .addr(ia.addr), .wdata(ia.wdata),
      .ack(ia.ack), .err(ia.err), .rdata(ia.rdata), .hung(ia.hung));
   // ----------------------------------------------
   // Helpers
   // ----------------------------------------------
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   // Random word-aligned slot inside region r
   function logic [11:0] slot(int r);
      return crl_pkg::REGION_BASE + 12'(r * 128) + 12'((xs() % 32) * 4);
   endfunction : slot
   function logic [31:0] lk(int r);
      return (r == 4) ? 32'h143f832c : crl_pkg::LOCK_CODE[r];
   endfunction : lk
   function logic [31:0] ul(int r);
      return (r == 4) ? 32'h6f361e05 : crl_pkg::UNLOCK_CODE[r];
   endfunction : ul
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // One bus cycle: strobe one edge; the answer launched by the taking
   // edge is read just after it, once it has settled
   task acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      ib.req <= 1'b1; ib.we <= w; ib.addr <= ad; ib.wdata <= d;
      @(posedge clk_sys);
      ib.req <= 1'b0;
      #1;
      ok = ib.ack === 1'b1;
      rd = ib.rdata;
      er = ib.err;
   endtask : acc
   task end_sim();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Watchdog: the whole sequence needs well under this span
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      end_sim();
   end
   // ----------------------------------------------
   // Main sequence
   // ----------------------------------------------
   initial begin
      seed = 32'h00000044; failures = 0; checked = 0; rst = 1'b1;
      start = 1'b0; pad_addr = 12'h000; pad_data = 32'h00000000;
      ib.req = 1'b0; ib.we = 1'b0; ib.addr = 12'h000; ib.wdata = 32'h0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) begin
         acc(1'b0, 12'(i), 32'h0);
         check(rd, lk(i));
      end
      check(32'(lock_b), 32'h1f);
      // Each region: junk code, unlock, write, relock; dropped write in the first four only
      for (i = 0; i < 5; i++) begin
         a = slot(i);
         d1 = xs();
         acc(1'b1, 12'(i), xs());
         check(32'(lock_b[i]), 32'h1);
         acc(1'b1, 12'(i), ul(i));
         check(32'(lock_b[i]), 32'h0);
         acc(1'b1, a, d1);
         acc(1'b0, a, 32'h0);
         check(rd, d1);
         acc(1'b1, 12'(i), lk(i));
         check(32'(lock_b[i]), 32'h1);
         if (i < 4) begin
            acc(1'b1, a, ~d1);
            check(32'({ok, er}), 32'h2);
            acc(1'b0, a, 32'h0);
            check(rd, d1);
         end
      end
      // Forbidden write into the locked fifth region
      acc(1'b1, slot(4), xs());
      check(32'({ok, er}), 32'h3);
      acc(1'b0, crl_pkg::REGION_BASE, 32'h0);
      check(32'({ok, ib.hung, blocked_b}), 32'h3);
      repeat (50) @(posedge clk_sys);
      acc(1'b0, 12'h004, 32'h0);
      check(32'({ok, ib.hung}), 32'h1);
      // Only a reset clears the blocked space
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      check(32'({blocked_b, lock_b}), 32'h1f);
      // Master runs the safe update back to back
      for (i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         start <= 1'b1; pad_addr <= slot(4); pad_data <= xs();
         @(posedge clk_sys);
         start <= 1'b0;
         ok = 1'b0;
         repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (done === 1'b1) ok = 1'b1;
         end
         check(32'({ok, blocked_a, lock_a}), 32'h5f);
         check(u_crl_space.mem[pad_addr[11:2]], pad_data);
      end
      end_sim();
   end
endmodule : config_region_write_lock_test
